// [verilog/adcp_defs.vh]
// constants of the serial converter port: register map, fields, timing
// assumes a 125 MHz system clock and a 4-bit word address on the register port
`ifndef ADCP_DEFS_VH
`define ADCP_DEFS_VH

// ==================================================
// register word addresses
`define ADCP_ADDR_STATUS   4'h0
`define ADCP_ADDR_MASK     4'h1
`define ADCP_ADDR_STATE    4'h2
`define ADCP_ADDR_RESULT   4'h3

// ==================================================
// status and mask bit positions
`define ADCP_EV_DONE       0
`define ADCP_EV_NAP        1
`define ADCP_EV_SLEEP      2
`define ADCP_EV_WAKE       3
`define ADCP_EV_SETTLED    4
`define ADCP_EV_W          5

// ==================================================
// state register bit positions
`define ADCP_ST_PWR_LO     0
`define ADCP_ST_PWR_HI     1
`define ADCP_ST_FLAG       2
`define ADCP_ST_RANGE      3
`define ADCP_ST_ACQ        4
`define ADCP_ST_BUSY       5

// ==================================================
// reset values
`define ADCP_MASK_RST      5'h00
`define ADCP_RESULT_RST    12'h000

// ==================================================
// serial sequence counts
`define ADCP_RES_W         12
`define ADCP_WORD_BITS     13
`define ADCP_CONVERT_STROBE_EDGES    4'hE
`define ADCP_NAP_PULSES    3'h2
`define ADCP_SLEEP_PULSES  3'h4

// ==================================================
// timing: reference settle plus flag delay after sleep wake
`define ADCP_CLK_MHZ       125
`define ADCP_REF_SETTLE_US 12000

`endif

// [verilog/adcp_pin_sync.v]
// two-flop synchronisers with edge detection for the host pins
// assumes pins are asynchronous to clk and reset is already synchronised
`timescale 1ns/1ps

module adcp_pin_sync (
  clk,
  rst_n,
  pin_in,
  level,
  rise,
  fall
);
  input  wire       clk;
  input  wire       rst_n;
  input  wire [2:0] pin_in;
  output wire [2:0] level;
  output wire [2:0] rise;
  output wire [2:0] fall;

  genvar g;

  // ==================================================
  // per-pin synchroniser and edge history
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_pin
      reg meta_q;
      reg sync_q;
      reg prev_q;
      // first flop feeds only the second one
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end
        else
        begin
          meta_q <= pin_in[g];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      // edges seen between second and third stage
      assign level[g] = sync_q;
      assign rise[g]  = sync_q & ~prev_q;
      assign fall[g]  = ~sync_q & prev_q;
    end
  endgenerate

endmodule // adcp_pin_sync

// [verilog/adcp_port.v]
// serial converter control and output port, device side
// assumes host drives sck and convert_strobe slowly against clk (sck period >= 4 clk)
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "adcp_defs.vh"

// Functional notes
// - range strap: low unipolar, high bipolar coding
// - output word carries previous conversion's sample
// - each sck rise advances sequence, next bit
// - strobe rise holds input, starts conversion
// - two strobes, sck static: enter nap
// - four strobes, sck static: enter sleep
// - any sck pulse wakes from nap/sleep
// - acquisition from fourteenth sck rise to strobe
// - sleep clears settled flag; set after settling
module adcp_port #(
  parameter SETTLE_CYCLES = `ADCP_REF_SETTLE_US * `ADCP_CLK_MHZ
) (
  clk,
  arst_n,
  sck,
  convert_strobe,
  range_select,
  analog_code,
  dout,
  dout_oe_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  irq
);
  input  wire        clk;
  input  wire        arst_n;
  input  wire        sck;
  input  wire        convert_strobe;
  input  wire        range_select;
  input  wire [11:0] analog_code;
  output wire        dout;
  output wire        dout_oe_n;
  input  wire [3:0]  reg_addr;
  input  wire [15:0] reg_wdata;
  input  wire        reg_wr;
  input  wire        reg_rd;
  output wire [15:0] reg_rdata;
  output wire        irq;

  localparam PWR_ACTIVE = 2'b00;
  localparam PWR_NAP    = 2'b01;
  localparam PWR_SLEEP  = 2'b10;

  reg        rst_meta_q;
  reg        rst_n_q;
  wire [2:0] pin_level;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;
  reg [11:0] ain_meta_q;
  reg [11:0] ain_sync_q;
  reg [1:0]  pwr_q;
  reg [1:0]  pwr_d;
  reg [2:0]  pulse_cnt_q;
  reg [2:0]  pulse_cnt_d;
  reg [3:0]  edge_cnt_q;
  reg [3:0]  edge_cnt_d;
  reg        busy_q;
  reg        busy_d;
  reg        acq_q;
  reg        acq_d;
  reg [11:0] hold_q;
  reg [11:0] hold_d;
  reg [11:0] result_q;
  reg [11:0] result_d;
  reg [12:0] word_q;
  reg [12:0] word_d;
  reg        dout_q;
  reg        dout_d;
  reg        oe_n_q;
  reg        oe_n_d;
  reg        flag_q;
  reg        flag_d;
  reg        settling_q;
  reg        settling_d;
  reg [20:0] settle_cnt_q;
  reg [20:0] settle_cnt_d;
  reg [4:0]  events;
  reg [4:0]  status_q;
  reg [4:0]  mask_q;
  reg [15:0] rdata_q;
  reg [15:0] rdata_d;

  wire sck_rise  = pin_rise[0];
  wire sck_edge  = pin_rise[0] | pin_fall[0];
  wire convert_strobe_rise = pin_rise[1];
  wire range_bip = pin_level[2];
  wire [2:0] pulse_next = (pulse_cnt_q == `ADCP_SLEEP_PULSES) ? pulse_cnt_q : pulse_cnt_q + 3'h1;
  wire [3:0] edge_next  = edge_cnt_q + 4'h1;

  // code of a held sample: bipolar flips the msb to two's complement
  function [11:0] adcp_code;
    input [11:0] raw;
    input        bip;
    begin
      adcp_code = {raw[11] ^ bip, raw[10:0]};
    end
  endfunction

  // ==================================================
  // reset release through two flops
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ==================================================
  // pin synchronisers: sck, strobe, range strap
  adcp_pin_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n_q),
    .pin_in ({range_select, convert_strobe, sck}),
    .level  (pin_level),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  // analog code crosses in two flops, it is steady around the strobe
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ain_meta_q <= 12'h000;
      ain_sync_q <= 12'h000;
    end
    else
    begin
      ain_meta_q <= analog_code;
      ain_sync_q <= ain_meta_q;
    end
  end

  // ==================================================
  // conversion, serial output and power sequencing
  always @*
  begin
    pwr_d        = pwr_q;
    pulse_cnt_d  = pulse_cnt_q;
    edge_cnt_d   = edge_cnt_q;
    busy_d       = busy_q;
    acq_d        = acq_q;
    hold_d       = hold_q;
    result_d     = result_q;
    word_d       = word_q;
    dout_d       = dout_q;
    oe_n_d       = oe_n_q;
    flag_d       = flag_q;
    settling_d   = settling_q;
    settle_cnt_d = settle_cnt_q;
    events       = 5'h00;
    if (sck_edge)
    begin
      pulse_cnt_d = 3'h0;
      if (pwr_q != PWR_ACTIVE)
      begin
        pwr_d = PWR_ACTIVE;
        events[`ADCP_EV_WAKE] = 1'b1;
        if (pwr_q == PWR_SLEEP)
        begin
          settling_d   = 1'b1;
          settle_cnt_d = 21'h000000;
        end
      end
    end
    if (sck_rise && busy_q)
    begin
      edge_cnt_d = edge_next;
      if (edge_next < `ADCP_WORD_BITS)
        dout_d = word_q[`ADCP_WORD_BITS - 1 - edge_next];
      else
        oe_n_d = 1'b1;
      if (edge_next == `ADCP_CONVERT_STROBE_EDGES)
      begin
        busy_d   = 1'b0;
        acq_d    = 1'b1;
        result_d = adcp_code(hold_q, range_bip);
        events[`ADCP_EV_DONE] = 1'b1;
      end
    end
    if (convert_strobe_rise)
    begin
      pulse_cnt_d = pulse_next;
      if (pulse_next == 3'h1)
      begin
        hold_d     = ain_sync_q;
        acq_d      = 1'b0;
        busy_d     = 1'b1;
        edge_cnt_d = 4'h0;
        word_d     = {flag_q, result_q};
        dout_d     = flag_q;
        oe_n_d     = 1'b0;
      end
      else if (pulse_next == `ADCP_NAP_PULSES)
      begin
        pwr_d  = PWR_NAP;
        busy_d = 1'b0;
        oe_n_d = 1'b1;
        events[`ADCP_EV_NAP] = 1'b1;
      end
      else if (pulse_next == `ADCP_SLEEP_PULSES && pulse_cnt_q != `ADCP_SLEEP_PULSES)
      begin
        pwr_d      = PWR_SLEEP;
        busy_d     = 1'b0;
        oe_n_d     = 1'b1;
        flag_d     = 1'b0;
        settling_d = 1'b0;
        events[`ADCP_EV_SLEEP] = 1'b1;
      end
    end
    if (settling_q && pwr_q == PWR_ACTIVE && pwr_d == PWR_ACTIVE)
    begin
      if (settle_cnt_q >= SETTLE_CYCLES[20:0] - 21'h000001)
      begin
        settling_d = 1'b0;
        flag_d     = 1'b1;
        events[`ADCP_EV_SETTLED] = 1'b1;
      end
      else
        settle_cnt_d = settle_cnt_q + 21'h000001;
    end
  end

  // state flops; after reset the reference settles as after a sleep wake
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pwr_q        <= PWR_ACTIVE;
      pulse_cnt_q  <= 3'h0;
      edge_cnt_q   <= 4'h0;
      busy_q       <= 1'b0;
      acq_q        <= 1'b1;
      hold_q       <= 12'h000;
      result_q     <= `ADCP_RESULT_RST;
      word_q       <= 13'h0000;
      dout_q       <= 1'b0;
      oe_n_q       <= 1'b1;
      flag_q       <= 1'b0;
      settling_q   <= 1'b1;
      settle_cnt_q <= 21'h000000;
    end
    else
    begin
      pwr_q        <= pwr_d;
      pulse_cnt_q  <= pulse_cnt_d;
      edge_cnt_q   <= edge_cnt_d;
      busy_q       <= busy_d;
      acq_q        <= acq_d;
      hold_q       <= hold_d;
      result_q     <= result_d;
      word_q       <= word_d;
      dout_q       <= dout_d;
      oe_n_q       <= oe_n_d;
      flag_q       <= flag_d;
      settling_q   <= settling_d;
      settle_cnt_q <= settle_cnt_d;
    end
  end

  assign dout      = dout_q;
  assign dout_oe_n = oe_n_q;

  // ==================================================
  // register port: sticky status with write-one clear, mask, read data
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      status_q <= 5'h00;
      mask_q   <= `ADCP_MASK_RST;
    end
    else
    begin
      // a new event wins over its clear
      if (reg_wr && reg_addr == `ADCP_ADDR_STATUS)
        status_q <= (status_q & ~reg_wdata[`ADCP_EV_W-1:0]) | events;
      else
        status_q <= status_q | events;
      if (reg_wr && reg_addr == `ADCP_ADDR_MASK)
        mask_q <= reg_wdata[`ADCP_EV_W-1:0];
    end
  end

  // read mux, unmapped words read zero
  always @*
  begin
    rdata_d = 16'h0000;
    case (reg_addr)
      `ADCP_ADDR_STATUS: rdata_d = {11'h000, status_q};
      `ADCP_ADDR_MASK:   rdata_d = {11'h000, mask_q};
      `ADCP_ADDR_STATE:  rdata_d = {10'h000, busy_q, acq_q, range_bip, flag_q, pwr_q};
      `ADCP_ADDR_RESULT: rdata_d = {4'h0, result_q};
      default:           rdata_d = 16'h0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_q <= 16'h0000;
    else if (reg_rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= 16'h0000;
  end

  assign reg_rdata = rdata_q;
  assign irq       = |(status_q & mask_q);
endmodule // adcp_port

// [test/adcp_port_chk.sv]
// checker on the pins and register port of the converter port
// assumes binding onto adcp_port, one clock domain
`timescale 1ns/1ps

module adcp_port_chk (
  input wire        clk,
  input wire        arst_n,
  input wire        sck,
  input wire        convert_strobe,
  input wire        range_select,
  input wire        dout,
  input wire        dout_oe_n,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        irq
);
  reg [6:0] sck_q;
  reg [6:0] cnv_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // pin histories, newest in bit 0
  always @(posedge clk)
  begin
    sck_q <= {sck_q[5:0], sck};
    cnv_q <= {cnv_q[5:0], convert_strobe};
  end

  // ==========
  // register port
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h3 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_high_zero: assert property (reg_rd |=> reg_rdata[15:12] == 4'h0)
    else $error("unused read bits set");
  a_range_bit: assert property (reg_rd && reg_addr == 4'h2 && $past(range_select, 4) == range_select
    |=> reg_rdata[3] == $past(range_select)) else $error("range bit wrong");
  a_mask_quiet: assert property (reg_wr && reg_addr == 4'h1 && reg_wdata[4:0] == 5'h00 |=> !irq)
    else $error("irq with mask clear");
  a_reset_idle: assert property (disable iff (1'b0) !arst_n |-> dout_oe_n && !irq && reg_rdata == 16'h0000)
    else $error("outputs active in reset");

  // ==========
  // serial output
  a_bit_step: assert property ($changed(dout) && !dout_oe_n && !$past(dout_oe_n)
    |-> (sck_q[5:2] & ~sck_q[6:3]) != 4'h0) else $error("bit moved without sck rise");
  a_word_start: assert property ($fell(dout_oe_n) |-> (cnv_q[5:2] & ~cnv_q[6:3]) != 4'h0)
    else $error("word began without strobe");
endmodule // adcp_port_chk

bind adcp_port adcp_port_chk adcp_port_chk_i (.clk(clk), .arst_n(arst_n), .sck(sck),
  .convert_strobe(convert_strobe), .range_select(range_select), .dout(dout), .dout_oe_n(dout_oe_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq));

// [test/adcp_host_model.sv]
// host model: drives strobe and serial clock, collects sample words
// assumes its tasks are called right after a rising edge of clk
`timescale 1ns/1ps

module adcp_host_model (
  input  wire clk,
  output reg  sck,
  output reg  convert_strobe,
  input  wire dout,
  input  wire dout_oe_n
);
  integer    hp;
  reg [12:0] word;
  reg        drv;
  event      got;
  // a released line shows the inverse of the last bit, so an early release is caught
  wire       dout_seen = dout_oe_n ? ~dout : dout;

  // ==========
  // idle levels; 10 clocks a half period give 80 ns
  initial
  begin
    sck = 1'b0;
    convert_strobe = 1'b0;
    hp = 10;
  end

  // one strobe pulse, serial clock still
  task pulse;
    begin
      repeat (4) @(posedge clk);
      convert_strobe <= 1'b1;
      repeat (hp) @(posedge clk);
      convert_strobe <= 1'b0;
      repeat (hp) @(posedge clk);
    end
  endtask

  task strobes(input integer n);
    repeat (n) pulse;
  endtask

  task wake;
    begin
      sck <= 1'b1;
      repeat (hp) @(posedge clk);
      sck <= 1'b0;
      repeat (hp) @(posedge clk);
    end
  endtask

  // sample before each of the first thirteen rises, released at end
  task frame;
    integer k;
    begin
      drv = 1'b1;
      pulse;
      for (k = 0; k < 14; k = k + 1)
      begin
        if (k < 13)
        begin
          word = {word[11:0], dout_seen};
          drv = drv & ~dout_oe_n;
        end
        wake;
      end
      drv = drv & dout_oe_n;
      -> got;
    end
  endtask
endmodule // adcp_host_model

// [test/test_adcp_port.sv]
// bench: two resets, frames, power states, registers, interrupt
// assumes the port, host model and checker are compiled first
`timescale 1ns/1ps

module test_adcp_port;
  reg         clk;
  reg         arst_n;
  reg         range_select;
  reg  [11:0] analog_code;
  reg  [3:0]  reg_addr;
  reg  [15:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  reg         rd_d;
  wire        sck;
  wire        convert_strobe;
  wire        dout;
  wire        dout_oe_n;
  wire [15:0] reg_rdata;
  wire        irq;
  integer     seed;
  integer     miscompares;
  integer     n_tests;
  reg  [31:0] rq[$];
  reg  [27:0] wq[$];
  reg  [31:0] e;
  reg  [27:0] w;
  reg  [13:0] g;

  adcp_port #(.SETTLE_CYCLES(50)) adcp_port_i (.clk(clk), .arst_n(arst_n), .sck(sck),
    .convert_strobe(convert_strobe), .range_select(range_select), .analog_code(analog_code),
    .dout(dout), .dout_oe_n(dout_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  adcp_host_model adcp_host_model_i (.clk(clk), .sck(sck), .convert_strobe(convert_strobe),
    .dout(dout), .dout_oe_n(dout_oe_n));

  // ==========
  // clock, compare and verdict
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task check(input [47:0] nm, input [15:0] x, input [15:0] s);
    begin
      n_tests = n_tests + 1;
      if (s !== x)
      begin
        miscompares = miscompares + 1;
        $display("ERROR %0s expected %h seen %h", nm, x, s);
      end
    end
  endtask

  // one compare per kind of result, all through the common counters
  task check_reg(input [15:0] x, input [15:0] s);
    begin
      check("reg", x, s);
    end
  endtask

  task check_word(input [15:0] x, input [15:0] s);
    begin
      check("word", x, s);
    end
  endtask

  task check_irq(input x);
    begin
      check("irq", {15'h0000, x}, {15'h0000, irq});
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // register reads: oldest note against read data
  always @(posedge clk)
  begin
    if (rd_d)
    begin
      e = rq.pop_front();
      check_reg(e[15:0], reg_rdata & e[31:16]);
    end
    rd_d <= reg_rd;
  end

  // words: oldest note against the collected word
  always @(adcp_host_model_i.got)
  begin
    w = wq.pop_front();
    g = {adcp_host_model_i.drv, adcp_host_model_i.word};
    check_word({2'b00, w[13:0] & w[27:14]}, {2'b00, g & w[27:14]});
  end

  // ==========
  // register port master
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask

  task rd(input [3:0] a, input [15:0] m, input [15:0] x);
    begin
      rq.push_back({m, x});
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
    end
  endtask

  // reset with a strap level, then frames, interrupt and power states
  task run(input reg r);
    integer i;
    reg [11:0] a;
    reg [11:0] p;
    begin
      p = 12'h000;
      @(posedge clk);
      arst_n <= 1'b0;
      range_select <= r;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (80) @(posedge clk);
      rd(4'h1, 16'hFFFF, 16'h0000);
      wr(4'h9, 16'($random(seed)));
      rd(4'h9, 16'hFFFF, 16'h0000);
      rd(4'h2, 16'h000F, {12'h000, r, 3'h4});
      for (i = 0; i < 4; i = i + 1)
      begin
        a = 12'($random(seed));
        analog_code <= a;
        wq.push_back({1'b1, {13{i > 0}}, 2'b11, p ^ {r, 11'h000}});
        adcp_host_model_i.frame;
        p = a;
        rd(4'h3, 16'hFFFF, {4'h0, a ^ {r, 11'h000}});
        rd(4'h2, 16'h0033, 16'h0010);
      end
      rd(4'h0, 16'h0001, 16'h0001);
      check_irq(1'b0);
      wr(4'h1, 16'h0001);
      @(posedge clk);
      check_irq(1'b1);
      wr(4'h0, 16'h001F);
      @(posedge clk);
      check_irq(1'b0);
      wr(4'h1, 16'h0000);
      adcp_host_model_i.strobes(2);
      rd(4'h2, 16'h0003, 16'h0001);
      rd(4'h0, 16'h0002, 16'h0002);
      adcp_host_model_i.strobes(2);
      rd(4'h2, 16'h0007, 16'h0002);
      adcp_host_model_i.wake;
      rd(4'h2, 16'h0007, 16'h0000);
      repeat (80) @(posedge clk);
      rd(4'h2, 16'h0007, 16'h0004);
      rd(4'h0, 16'h001C, 16'h001C);
      wq.push_back({14'h3000, 14'h3000});
      adcp_host_model_i.frame;
    end
  endtask

  // main sequence: second reset lands after the first run ends, with bipolar strap
  initial
  begin
    arst_n = 1'b1; // asserted at the first edge, clear of the time-zero race
    range_select = 1'b0;
    analog_code = 12'h000;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d = 1'b0;
    seed = 96113;
    miscompares = 0;
    n_tests = 0;
    run(1'b0);
    run(1'b1);
    print_verdict;
  end

  // watchdog, about ten times the expected run
  initial
  begin
    #300000;
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule // test_adcp_port
